// file: supply_status_regs.svh
// register offsets, field positions and widths for the supply status bank
`ifndef SUPPLY_STATUS_REGS_SVH
`define SUPPLY_STATUS_REGS_SVH

`define OV_FLAGS_A_ADDR     8'hE2
`define OV_FLAGS_B_ADDR     8'hE3
`define UV_FLAGS_A_ADDR     8'hE4
`define UV_FLAGS_B_ADDR     8'hE5
`define LIM_FLAGS_A_ADDR    8'hE6
`define LIM_FLAGS_B_ADDR    8'hE7
`define LOGIC_LEVELS_ADDR   8'hE8

`define STATUS_RESET        8'h00
`define UNMAPPED_READ       8'h00

`define SUPPLY_COUNT        5
`define DUAL_COUNT          5
`define LIMIT_COUNT         10
`define COMP_COUNT          30

`define FLAG_A_DUAL_LSB     5
`define FLAG_B_USED_W       2
`define FLAG_B_PAD_W        6
`define LEVELS_USED_W       5
`define LEVELS_PAD_W        3

`endif

// file: supply_status_pkg.sv
// shared types for the supply status bank
package supply_status_pkg;

  typedef logic [7:0] status_byte_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_OV_A,
    SEL_OV_B,
    SEL_UV_A,
    SEL_UV_B,
    SEL_LIM_A,
    SEL_LIM_B,
    SEL_LEVELS
  } reg_sel_e;

endpackage

// file: comparator_sync.sv
// two-flop synchroniser for asynchronous comparator outputs
`timescale 1ns/100ps
`include "supply_status_regs.svh"

module comparator_sync
  import supply_status_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic [`COMP_COUNT-1:0]  async_in,
  output logic      [`COMP_COUNT-1:0]  sync_out
);

  logic [`COMP_COUNT-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < `COMP_COUNT; i = i + 1)
    begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          meta_q[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

// file: black_box_snapshot.sv
// snapshot of the status bytes taken on each engine state change
`timescale 1ns/100ps
`include "supply_status_regs.svh"

module black_box_snapshot
  import supply_status_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          capture,
  input  wire status_byte_t  ov_a,
  input  wire status_byte_t  ov_b,
  input  wire status_byte_t  uv_a,
  input  wire status_byte_t  uv_b,
  input  wire status_byte_t  lim_a,
  input  wire status_byte_t  lim_b,
  input  wire status_byte_t  levels,
  output status_byte_t       snap_ov_a,
  output status_byte_t       snap_ov_b,
  output status_byte_t       snap_uv_a,
  output status_byte_t       snap_uv_b,
  output status_byte_t       snap_lim_a,
  output status_byte_t       snap_lim_b,
  output status_byte_t       snap_levels
);

  // holds until the next state change, unlike the live bytes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      snap_ov_a   <= `STATUS_RESET;
      snap_ov_b   <= `STATUS_RESET;
      snap_uv_a   <= `STATUS_RESET;
      snap_uv_b   <= `STATUS_RESET;
      snap_lim_a  <= `STATUS_RESET;
      snap_lim_b  <= `STATUS_RESET;
      snap_levels <= `STATUS_RESET;
    end
    else if (capture) // [RULE_12]
    begin
      snap_ov_a   <= ov_a;
      snap_ov_b   <= ov_b;
      snap_uv_a   <= uv_a;
      snap_uv_b   <= uv_b;
      snap_lim_a  <= lim_a;
      snap_lim_b  <= lim_b;
      snap_levels <= levels;
    end
  end

  a_snap_capture: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
    capture |=> (snap_ov_a == $past(ov_a)) && (snap_uv_a == $past(uv_a))
      && (snap_lim_a == $past(lim_a)) && (snap_levels == $past(levels)))
    else $error("snapshot did not take the status bytes");

  a_snap_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
    !capture |=> $stable(snap_ov_b) && $stable(snap_uv_b) && $stable(snap_lim_b))
    else $error("snapshot changed without a state change");

endmodule

// file: supply_status_warning_regs.sv
// live supply status registers, warning aggregation and snapshot hookup
// Behaviour
// RULE_01: warning is the OR of all ADC limit flags and secondary detector outputs.
// RULE_02: secondary detectors count only when their dual input is a logic input.
// RULE_03: status registers read any time, show live state, ignore writes.
// RULE_04: first over register bits 0-3 positive supplies 1-4, bit 4 high voltage.
// RULE_05: first over bits 5-7 dual inputs 1-3 or supply 1-3 secondary warning.
// RULE_06: second over bit 0 dual 4 / supply 4, bit 1 dual 5 / high voltage.
// RULE_07: first under register mirrors first over mapping for undervoltage.
// RULE_08: second under bit 0 dual 4 / supply 4, bit 1 dual 5 / high voltage.
// RULE_09: first limit register holds channel flags, supply 1 at bit 0 up to dual 3.
// RULE_10: second limit register holds dual 4 and 5 flags in bits 0 and 1.
// RULE_11: logic level register shows conditioned dual inputs 1-5 in bits 0-4.
// RULE_12: each engine state change copies all status bytes into snapshot registers.
// RULE_13: unusable status bits read zero; writes to status registers do nothing.
`timescale 1ns/100ps
`include "supply_status_regs.svh"

module supply_status_warning_regs
  import supply_status_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic [3:0]               over_flag_positive,
  input  wire logic                     over_flag_high,
  input  wire logic [`DUAL_COUNT-1:0]   over_flag_dual,
  input  wire logic [`SUPPLY_COUNT-1:0] over_flag_secondary,
  input  wire logic [3:0]               under_flag_positive,
  input  wire logic                     under_flag_high,
  input  wire logic [`DUAL_COUNT-1:0]   under_flag_dual,
  input  wire logic [`SUPPLY_COUNT-1:0] under_flag_secondary,
  input  wire logic [`DUAL_COUNT-1:0]   dual_function_is_logic,
  input  wire logic [`LIMIT_COUNT-1:0]  limit_flag,
  input  wire logic [`DUAL_COUNT-1:0]   logic_level_dual,
  input  wire logic                     sequencing_engine_step,
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_wr,
  input  wire logic [7:0]               reg_wdata,
  output status_byte_t                  reg_rdata,
  output logic                          reg_rvalid,
  output logic                          sequencing_engine_warning,
  output status_byte_t                  snap_ov_a,
  output status_byte_t                  snap_ov_b,
  output status_byte_t                  snap_uv_a,
  output status_byte_t                  snap_uv_b,
  output status_byte_t                  snap_lim_a,
  output status_byte_t                  snap_lim_b,
  output status_byte_t                  snap_levels
);

  logic [`COMP_COUNT-1:0]   comp_raw;
  logic [`COMP_COUNT-1:0]   comp_s;
  logic [`SUPPLY_COUNT-1:0] ov_pri;
  logic [`DUAL_COUNT-1:0]   ov_dual;
  logic [`SUPPLY_COUNT-1:0] ov_sec;
  logic [`SUPPLY_COUNT-1:0] uv_pri;
  logic [`DUAL_COUNT-1:0]   uv_dual;
  logic [`SUPPLY_COUNT-1:0] uv_sec;
  logic [`SUPPLY_COUNT-1:0] ov_sec_live;
  logic [`SUPPLY_COUNT-1:0] uv_sec_live;
  logic [`DUAL_COUNT-1:0]   ov_ext;
  logic [`DUAL_COUNT-1:0]   uv_ext;
  logic                     warning_d;
  status_byte_t             ov_a_q;
  status_byte_t             ov_b_q;
  status_byte_t             uv_a_q;
  status_byte_t             uv_b_q;
  status_byte_t             lim_a_q;
  status_byte_t             lim_b_q;
  status_byte_t             levels_q;
  status_byte_t             rdata_d;
  reg_sel_e                 sel;
  logic                     wdata_unused;

  // comparators are analog and asynchronous to clk
  assign comp_raw = {under_flag_secondary, under_flag_dual, under_flag_high,
                     under_flag_positive, over_flag_secondary, over_flag_dual,
                     over_flag_high, over_flag_positive};

  comparator_sync u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (comp_raw),
    .sync_out (comp_s)
  );

  assign ov_pri  = comp_s[4:0];
  assign ov_dual = comp_s[9:5];
  assign ov_sec  = comp_s[14:10];
  assign uv_pri  = comp_s[19:15];
  assign uv_dual = comp_s[24:20];
  assign uv_sec  = comp_s[29:25];

  // a pin in detector mode has no secondary detector behind it
  assign ov_sec_live = ov_sec & dual_function_is_logic; // [RULE_02]
  assign uv_sec_live = uv_sec & dual_function_is_logic; // [RULE_02]

  // shared bit slots: dual detector or secondary warning, per pin mode
  assign ov_ext = ov_sec_live | (ov_dual & ~dual_function_is_logic); // [RULE_05] [RULE_06]
  assign uv_ext = uv_sec_live | (uv_dual & ~dual_function_is_logic); // [RULE_07] [RULE_08]

  assign warning_d = (|limit_flag) | (|ov_sec_live) | (|uv_sec_live); // [RULE_01]

  // live bytes refreshed every cycle; nothing here latches a fault
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ov_a_q <= `STATUS_RESET;
      ov_b_q <= `STATUS_RESET;
    end
    else
    begin
      ov_a_q <= {ov_ext[2:0], ov_pri}; // [RULE_04] [RULE_05] [RULE_03]
      ov_b_q <= {{`FLAG_B_PAD_W{1'b0}}, ov_ext[4:3]}; // [RULE_06] [RULE_13]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      uv_a_q <= `STATUS_RESET;
      uv_b_q <= `STATUS_RESET;
    end
    else
    begin
      uv_a_q <= {uv_ext[2:0], uv_pri}; // [RULE_07] [RULE_03]
      uv_b_q <= {{`FLAG_B_PAD_W{1'b0}}, uv_ext[4:3]}; // [RULE_08] [RULE_13]
    end
  end

  // limit flags arrive already judged against their sense setting
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lim_a_q <= `STATUS_RESET;
      lim_b_q <= `STATUS_RESET;
    end
    else
    begin
      lim_a_q <= limit_flag[7:0]; // [RULE_09]
      lim_b_q <= {{`FLAG_B_PAD_W{1'b0}}, limit_flag[9:8]}; // [RULE_10] [RULE_13]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      levels_q <= `STATUS_RESET;
    else
      levels_q <= {{`LEVELS_PAD_W{1'b0}}, logic_level_dual}; // [RULE_11] [RULE_13]
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sequencing_engine_warning <= 1'b0;
    else
      sequencing_engine_warning <= warning_d; // [RULE_01]
  end

  // address decode
  always_comb
  begin
    if (reg_addr == `OV_FLAGS_A_ADDR)
      sel = SEL_OV_A;
    else if (reg_addr == `OV_FLAGS_B_ADDR)
      sel = SEL_OV_B;
    else if (reg_addr == `UV_FLAGS_A_ADDR)
      sel = SEL_UV_A;
    else if (reg_addr == `UV_FLAGS_B_ADDR)
      sel = SEL_UV_B;
    else if (reg_addr == `LIM_FLAGS_A_ADDR)
      sel = SEL_LIM_A;
    else if (reg_addr == `LIM_FLAGS_B_ADDR)
      sel = SEL_LIM_B;
    else if (reg_addr == `LOGIC_LEVELS_ADDR)
      sel = SEL_LEVELS;
    else
      sel = SEL_NONE;
  end

  always_comb
  begin
    case (sel)
      SEL_OV_A:   rdata_d = ov_a_q;
      SEL_OV_B:   rdata_d = ov_b_q;
      SEL_UV_A:   rdata_d = uv_a_q;
      SEL_UV_B:   rdata_d = uv_b_q;
      SEL_LIM_A:  rdata_d = lim_a_q;
      SEL_LIM_B:  rdata_d = lim_b_q;
      SEL_LEVELS: rdata_d = levels_q;
      default:    rdata_d = `UNMAPPED_READ;
    endcase
  end

  // writes are accepted by the port but change nothing here
  assign wdata_unused = reg_wr & (|reg_wdata); // [RULE_13]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_rdata  <= `STATUS_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_d; // [RULE_03]
    end
  end

  black_box_snapshot u_snap (
    .clk         (clk),
    .reset_n     (reset_n),
    .capture     (sequencing_engine_step),
    .ov_a        (ov_a_q),
    .ov_b        (ov_b_q),
    .uv_a        (uv_a_q),
    .uv_b        (uv_b_q),
    .lim_a       (lim_a_q),
    .lim_b       (lim_b_q),
    .levels      (levels_q),
    .snap_ov_a   (snap_ov_a),
    .snap_ov_b   (snap_ov_b),
    .snap_uv_a   (snap_uv_a),
    .snap_uv_b   (snap_uv_b),
    .snap_lim_a  (snap_lim_a),
    .snap_lim_b  (snap_lim_b),
    .snap_levels (snap_levels)
  );

  a_warn_or_all: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_01]
    ##1 sequencing_engine_warning == $past((|limit_flag)
      | (|(comp_s[14:10] & dual_function_is_logic))
      | (|(comp_s[29:25] & dual_function_is_logic))))
    else $error("warning is not the OR of limits and secondary detectors");

  a_sec_gated: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_02]
    (dual_function_is_logic == 5'h00 && limit_flag == 10'h000)
      |=> !sequencing_engine_warning)
    else $error("secondary detector active in detector mode");

  a_ov_a_map: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
    ##1 ov_a_q[4:0] == $past(comp_s[4:0]))
    else $error("primary overvoltage bits misplaced");

  a_ov_dual_sel: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
    !dual_function_is_logic[0] |=> ov_a_q[5] == $past(comp_s[5]))
    else $error("dual input overvoltage not shown in detector mode");

  a_flag_b_pad: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_13]
    (ov_b_q[7:2] == 6'h00) && (uv_b_q[7:2] == 6'h00)
      && (lim_b_q[7:2] == 6'h00) && (levels_q[7:5] == 3'h0))
    else $error("unusable status bits not zero");

  a_uv_b_map: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_08]
    dual_function_is_logic[4] |=> uv_b_q[1] == $past(comp_s[29]))
    else $error("high voltage undervoltage warning misplaced");

  a_lim_map: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_09]
    ##1 (lim_a_q == $past(limit_flag[7:0])) && (lim_b_q[1:0] == $past(limit_flag[9:8])))
    else $error("limit flags misplaced");

  a_levels_live: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_11]
    ##1 levels_q[4:0] == $past(logic_level_dual))
    else $error("logic levels not live");

  a_read_data: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_03]
    (reg_rd && reg_addr == 8'hE7) |=> reg_rvalid && reg_rdata == $past(lim_b_q))
    else $error("read returned wrong status byte");

  a_write_ignored: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_13]
    (reg_wr && !reg_rd) |=> $stable(reg_rdata) && !reg_rvalid)
    else $error("write disturbed read data");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_13]
    (reg_rd && (reg_addr < 8'hE2 || reg_addr > 8'hE8)) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_ov_sec_sel: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
    dual_function_is_logic[0] |=> ov_a_q[5] == $past(comp_s[10]))
    else $error("secondary overvoltage warning not shown in logic mode");

  a_ov_b_dual: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
    (dual_function_is_logic[4:3] == 2'b00) |=> ov_b_q[1:0] == $past(comp_s[9:8]))
    else $error("dual input overvoltage misplaced in second byte");

  a_ov_b_sec: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
    (dual_function_is_logic[4:3] == 2'b11) |=> ov_b_q[1:0] == $past(comp_s[14:13]))
    else $error("secondary overvoltage warning misplaced in second byte");

  a_uv_a_map: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
    ##1 uv_a_q[4:0] == $past(comp_s[19:15]))
    else $error("primary undervoltage bits misplaced");

  a_uv_dual_sel: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
    !dual_function_is_logic[2] |=> uv_a_q[7] == $past(comp_s[22]))
    else $error("dual input undervoltage not shown in detector mode");

  a_warn_limit: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_01]
    (|limit_flag) |=> sequencing_engine_warning)
    else $error("limit flag did not raise the warning");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_03]
    !reg_rd |=> $stable(reg_rdata) && !reg_rvalid)
    else $error("read data moved without a read");

endmodule

// file: supply_status_partner.sv
// comparators, input conditioning and sequencing engine facing the status bank
`timescale 1ns/100ps

module supply_status_partner
(
  input  wire logic clk,
  output logic [3:0] over_flag_positive,
  output logic       over_flag_high,
  output logic [4:0] over_flag_dual,
  output logic [4:0] over_flag_secondary,
  output logic [3:0] under_flag_positive,
  output logic       under_flag_high,
  output logic [4:0] under_flag_dual,
  output logic [4:0] under_flag_secondary,
  output logic [4:0] dual_function_is_logic,
  output logic [9:0] limit_flag,
  output logic [4:0] logic_level_dual,
  output logic       sequencing_engine_step
);
  initial
  begin
    {over_flag_positive, over_flag_high, over_flag_dual, over_flag_secondary} = '0;
    {under_flag_positive, under_flag_high, under_flag_dual, under_flag_secondary} = '0;
    {dual_function_is_logic, limit_flag, logic_level_dual, sequencing_engine_step} = '0;
  end

  // comparator levels change just after an edge, as a real async source could
  task automatic drive(input logic [14:0] ov, input logic [14:0] uv, input logic [19:0] misc);
    @(posedge clk);
    {over_flag_positive, over_flag_high, over_flag_dual, over_flag_secondary} <= ov;
    {under_flag_positive, under_flag_high, under_flag_dual, under_flag_secondary} <= uv;
    {dual_function_is_logic, limit_flag, logic_level_dual} <= misc;
  endtask

  // one-cycle pulse per engine state change
  task automatic step();
    @(posedge clk);
    sequencing_engine_step <= 1'b1;
    @(posedge clk);
    sequencing_engine_step <= 1'b0;
  endtask
endmodule

// file: supply_status_warning_regs_tb_top.sv
// self-checking bench for the supply status bank
`timescale 1ns/100ps
`include "supply_status_regs.svh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

module supply_status_warning_regs_tb_top
  import supply_status_pkg::*;
;
  logic         clk;
  logic         reset_n;
  logic [7:0]   reg_addr;
  logic         reg_rd;
  logic         reg_wr;
  logic [7:0]   reg_wdata;
  status_byte_t reg_rdata;
  logic         reg_rvalid;
  logic         warn;
  status_byte_t snap [7];
  logic [3:0]   ovp, uvp;
  logic         ovh, uvh, step;
  logic [4:0]   ovd, ovs, uvd, uvs, is_logic, levels;
  logic [9:0]   limit;
  int           num_errors;
  int           checks;

  always #12.5 clk = ~clk;

  supply_status_partner u_supply_status_partner (.clk(clk), .over_flag_positive(ovp),
    .over_flag_high(ovh), .over_flag_dual(ovd), .over_flag_secondary(ovs),
    .under_flag_positive(uvp), .under_flag_high(uvh), .under_flag_dual(uvd),
    .under_flag_secondary(uvs), .dual_function_is_logic(is_logic), .limit_flag(limit),
    .logic_level_dual(levels), .sequencing_engine_step(step));

  supply_status_warning_regs u_supply_status_warning_regs (.clk(clk), .reset_n(reset_n),
    .over_flag_positive(ovp), .over_flag_high(ovh), .over_flag_dual(ovd),
    .over_flag_secondary(ovs), .under_flag_positive(uvp), .under_flag_high(uvh),
    .under_flag_dual(uvd), .under_flag_secondary(uvs), .dual_function_is_logic(is_logic),
    .limit_flag(limit), .logic_level_dual(levels), .sequencing_engine_step(step),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sequencing_engine_warning(warn),
    .snap_ov_a(snap[0]), .snap_ov_b(snap[1]), .snap_uv_a(snap[2]), .snap_uv_b(snap[3]),
    .snap_lim_a(snap[4]), .snap_lim_b(snap[5]), .snap_levels(snap[6]));

  // dual slot shows the secondary warning in logic mode, else its own detector
  function automatic logic [4:0] pick(logic [4:0] d, logic [4:0] s, logic [4:0] m);
    return (m & s) | (~m & d);
  endfunction

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input status_byte_t e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rvalid", 1'b1, reg_rvalid)
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic check_idle();
    for (int a = 'hE2; a <= 'hE9; a++)
      rd(a[7:0], 8'h00);
    `CHK("warning idle", 1'b0, warn)
  endtask

  // four logic-mode mixes for both detector paths and the warning gate
  task automatic check_mapping();
    logic [4:0] m [4] = '{5'b00110, 5'b11001, 5'b00000, 5'b11111};
    logic [4:0] vo, vu;
    for (int i = 0; i < 4; i++)
    begin
      u_supply_status_partner.drive({4'hA, 1'b1, 5'b10101, 5'b01010},
                                    {4'h5, 1'b0, 5'b01011, 5'b10100}, {m[i], 10'h000, 5'h00});
      settle();
      vo = pick(5'b10101, 5'b01010, m[i]);
      vu = pick(5'b01011, 5'b10100, m[i]);
      rd(`OV_FLAGS_A_ADDR, {vo[2:0], 1'b1, 4'hA});
      rd(`OV_FLAGS_B_ADDR, {6'h00, vo[4:3]});
      rd(`UV_FLAGS_A_ADDR, {vu[2:0], 1'b0, 4'h5});
      rd(`UV_FLAGS_B_ADDR, {6'h00, vu[4:3]});
      `CHK("warning secondary", |(m[i] & 5'b11110), warn)
    end
  endtask

  task automatic check_limits();
    logic [9:0] l [4] = '{10'h2A5, 10'h200, 10'h001, 10'h000};
    for (int i = 0; i < 4; i++)
    begin
      u_supply_status_partner.drive('0, '0, {5'h00, l[i], l[i][4:0]});
      settle();
      rd(`LIM_FLAGS_A_ADDR, l[i][7:0]);
      rd(`LIM_FLAGS_B_ADDR, {6'h00, l[i][9:8]});
      rd(`LOGIC_LEVELS_ADDR, {3'h0, l[i][4:0]});
      `CHK("warning limit", |l[i], warn)
    end
  endtask

  // status bytes are read-only; the written pattern must never show
  task automatic check_writes();
    u_supply_status_partner.drive('0, '0, {5'h00, 10'h2A5, 5'h05});
    for (int a = 'hE2; a <= 'hE9; a++)
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a[7:0];
      reg_wdata <= 8'hFF;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
    settle();
    rd(`OV_FLAGS_A_ADDR, 8'h00);
    rd(`LIM_FLAGS_A_ADDR, 8'hA5);
    rd(`LOGIC_LEVELS_ADDR, 8'h05);
    rd(8'hE9, 8'h00);
  endtask

  task automatic check_snap(input status_byte_t e [7]);
    for (int i = 0; i < 7; i++)
      `CHK("snapshot byte", e[i], snap[i])
  endtask

  task automatic check_snapshot();
    status_byte_t full [7] = '{8'h7A, 8'h02, 8'hA5, 8'h01, 8'hA5, 8'h02, 8'h15};
    status_byte_t zero [7] = '{default: 8'h00};
    u_supply_status_partner.drive({4'hA, 1'b1, 5'b10101, 5'b01010},
                                  {4'h5, 1'b0, 5'b01011, 5'b10100}, {5'b00110, 10'h2A5, 5'h15});
    settle();
    u_supply_status_partner.step();
    settle();
    check_snap(full);
    u_supply_status_partner.drive('0, '0, '0);
    settle();
    check_snap(full);
    u_supply_status_partner.step();
    settle();
    check_snap(zero);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    num_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    check_idle();
    check_mapping();
    check_limits();
    check_writes();
    check_snapshot();
    tally_and_finish();
  end
endmodule
